// [shared/ipr_pkg.sv]
// Package of register layout and constants for the interrupt priority register block.
`default_nettype none
package ipr_pkg;
   localparam logic [3:0]  IPR_OFF_PRIO0      = 4'h0;
   localparam logic [3:0]  IPR_OFF_PEND       = 4'h4;
   localparam logic [3:0]  IPR_OFF_WIN        = 4'h8;
   localparam int          IPR_CT_IS_LSB      = 0;
   localparam int          IPR_CT_IP_LSB      = 2;
   localparam int          IPR_CS0_IS_LSB     = 8;
   localparam int          IPR_CS0_IP_LSB     = 10;
   localparam int          IPR_CS1_IS_LSB     = 16;
   localparam int          IPR_CS1_IP_LSB     = 18;
   localparam logic [31:0] IPR_PRIO0_RESET    = 32'h0000_0000;
   localparam logic [31:0] IPR_PRIO0_WMASK    = 32'h001f_1f1f;
   localparam logic [1:0]  IPR_RESP_OKAY      = 2'h0;
   localparam logic [1:0]  IPR_RESP_SLVERR    = 2'h2;
   localparam logic [2:0]  IPR_PRIO_DISABLED  = 3'h0;
   localparam logic [1:0]  IPR_SRC_CT         = 2'h0;
   localparam logic [1:0]  IPR_SRC_CS0        = 2'h1;
   localparam logic [1:0]  IPR_SRC_CS1        = 2'h2;
   typedef enum logic [1:0] {
      IPR_IDLE = 2'b00,
      IPR_RESP = 2'b01
   } ipr_bus_e;
endpackage
`default_nettype wire

// [logic/ipr_arb.sv]
// Combinational arbiter that picks the winning source among three by priority then subpriority.
`timescale 1ns/1ns
`default_nettype none
module ipr_arb
   import ipr_pkg::*;
(
   // Per-source pending requests and settings.
   input  wire logic [2:0] pend,
   input  wire logic [8:0] prio,
   input  wire logic [5:0] sub,
   // Result.
   output logic            any,
   output logic [1:0]      win,
   output logic [2:0]      win_prio,
   output logic [1:0]      win_sub
);
   always_comb begin
      any      = 1'b0;
      win      = IPR_SRC_CT;
      win_prio = IPR_PRIO_DISABLED;
      win_sub  = 2'h0;
      for (int i = 0; i < 3; i++) begin
         // A zero level never competes, so a disabled source cannot win.
         if (pend[i] && prio[i*3 +: 3] != IPR_PRIO_DISABLED) begin
            // Levels compare as plain binary; subpriority only breaks ties.
            if (!any || prio[i*3 +: 3] > win_prio ||
                (prio[i*3 +: 3] == win_prio && sub[i*2 +: 2] > win_sub)) begin
               any      = 1'b1;
               win      = i[1:0];
               win_prio = prio[i*3 +: 3];
               win_sub  = sub[i*2 +: 2];
            end
         end
      end
   end
endmodule // ipr_arb
`default_nettype wire

// [logic/ipr_top.sv]
// Interrupt priority control register 0 with AXI4-Lite access and source arbitration.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ipr_top
   import ipr_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst,
   // AXI4-Lite write address.
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [3:0]  s_axi_awaddr,
   // AXI4-Lite write data.
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response.
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read address.
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [3:0]  s_axi_araddr,
   // AXI4-Lite read data.
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Pending requests: bit 0 core tick, bit 1 software 0, bit 2 software 1.
   input  wire logic [2:0]  irq_pend,
   // Arbitration result to the controller.
   output logic             irq_req,
   output logic [1:0]       irq_src,
   output logic [2:0]       irq_level,
   output logic [1:0]       irq_sublevel
);
   // Register and bus state.
   logic [31:0] prio0_ff,  nxt_prio0;
   logic        aw_got_ff, nxt_aw_got;
   logic [3:0]  aw_addr_ff, nxt_aw_addr;
   logic        w_got_ff,  nxt_w_got;
   logic [31:0] w_data_ff, nxt_w_data;
   logic [3:0]  w_strb_ff, nxt_w_strb;
   ipr_bus_e    wst_ff,    nxt_wst;
   logic [1:0]  bresp_ff,  nxt_bresp;
   ipr_bus_e    rst_ff,    nxt_rst;
   logic [31:0] rdata_ff,  nxt_rdata;
   logic [1:0]  rresp_ff,  nxt_rresp;
   logic        req_ff;
   logic [1:0]  src_ff;
   logic [2:0]  lvl_ff;
   logic [1:0]  sub_ff;
   logic        arb_any;
   logic [1:0]  arb_win;
   logic [2:0]  arb_prio;
   logic [1:0]  arb_sub;
   logic [8:0]  prio_vec;
   logic [5:0]  sub_vec;

   // Only the first register is writable; the others reflect state.
   function automatic logic addr_known(input logic [3:0] a);
      return a == IPR_OFF_PRIO0 || a == IPR_OFF_PEND || a == IPR_OFF_WIN;
   endfunction

   // Software interrupt 1 subpriority sits at bits 17 to 16 beside its priority.
   assign prio_vec = {prio0_ff[IPR_CS1_IP_LSB +: 3],
                      prio0_ff[IPR_CS0_IP_LSB +: 3],
                      prio0_ff[IPR_CT_IP_LSB +: 3]};
   assign sub_vec  = {prio0_ff[IPR_CS1_IS_LSB +: 2],
                      prio0_ff[IPR_CS0_IS_LSB +: 2],
                      prio0_ff[IPR_CT_IS_LSB +: 2]};

   ipr_arb u_arb (
      .pend     (irq_pend),
      .prio     (prio_vec),
      .sub      (sub_vec),
      .any      (arb_any),
      .win      (arb_win),
      .win_prio (arb_prio),
      .win_sub  (arb_sub)
   );

   // Write channel: address and data are latched independently, in any order.
   always_comb begin
      logic [31:0] bm;
      bm          = 32'h0000_0000;
      nxt_prio0   = prio0_ff;
      nxt_aw_got  = aw_got_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_got   = w_got_ff;
      nxt_w_data  = w_data_ff;
      nxt_w_strb  = w_strb_ff;
      nxt_wst     = wst_ff;
      nxt_bresp   = bresp_ff;
      if (s_axi_awvalid && !aw_got_ff && wst_ff == IPR_IDLE) begin
         nxt_aw_got  = 1'b1;
         nxt_aw_addr = {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && !w_got_ff && wst_ff == IPR_IDLE) begin
         nxt_w_got  = 1'b1;
         nxt_w_data = s_axi_wdata;
         nxt_w_strb = s_axi_wstrb;
      end
      case (wst_ff)
         IPR_IDLE: begin
            if (aw_got_ff && w_got_ff) begin
               for (int b = 0; b < 4; b++) begin
                  bm[b*8 +: 8] = {8{w_strb_ff[b]}};
               end
               // Reserved bits are masked so they never hold a value.
               if (aw_addr_ff == IPR_OFF_PRIO0) begin
                  nxt_prio0 = (prio0_ff & ~(bm & IPR_PRIO0_WMASK)) |
                              (w_data_ff & bm & IPR_PRIO0_WMASK);
               end
               nxt_bresp  = addr_known(aw_addr_ff) ? IPR_RESP_OKAY : IPR_RESP_SLVERR;
               nxt_aw_got = 1'b0;
               nxt_w_got  = 1'b0;
               nxt_wst    = IPR_RESP;
            end
         end
         IPR_RESP: begin
            if (s_axi_bready) begin
               nxt_wst = IPR_IDLE;
            end
         end
         default: nxt_wst = IPR_IDLE;
      endcase
   end

   // Read channel: data is captured at address acceptance and held until taken.
   always_comb begin
      logic [3:0] a;
      a         = {s_axi_araddr[3:2], 2'b00};
      nxt_rst   = rst_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      case (rst_ff)
         IPR_IDLE: begin
            if (s_axi_arvalid) begin
               nxt_rst   = IPR_RESP;
               nxt_rresp = addr_known(a) ? IPR_RESP_OKAY : IPR_RESP_SLVERR;
               if (a == IPR_OFF_PRIO0) begin
                  nxt_rdata = prio0_ff;
               end else if (a == IPR_OFF_PEND) begin
                  nxt_rdata = {29'h0000_0000, irq_pend};
               end else if (a == IPR_OFF_WIN) begin
                  nxt_rdata = {24'h00_0000, req_ff, src_ff, lvl_ff, sub_ff};
               end else begin
                  nxt_rdata = 32'h0000_0000;
               end
            end
         end
         IPR_RESP: begin
            if (s_axi_rready) begin
               nxt_rst = IPR_IDLE;
            end
         end
         default: nxt_rst = IPR_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prio0_ff   <= IPR_PRIO0_RESET;
         aw_got_ff  <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_got_ff   <= 1'b0;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
         wst_ff     <= IPR_IDLE;
         bresp_ff   <= IPR_RESP_OKAY;
         rst_ff     <= IPR_IDLE;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= IPR_RESP_OKAY;
         req_ff     <= 1'b0;
         src_ff     <= IPR_SRC_CT;
         lvl_ff     <= IPR_PRIO_DISABLED;
         sub_ff     <= 2'h0;
      end else begin
         prio0_ff   <= nxt_prio0;
         aw_got_ff  <= nxt_aw_got;
         aw_addr_ff <= nxt_aw_addr;
         w_got_ff   <= nxt_w_got;
         w_data_ff  <= nxt_w_data;
         w_strb_ff  <= nxt_w_strb;
         wst_ff     <= nxt_wst;
         bresp_ff   <= nxt_bresp;
         rst_ff     <= nxt_rst;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
         req_ff     <= arb_any;
         src_ff     <= arb_win;
         lvl_ff     <= arb_prio;
         sub_ff     <= arb_sub;
      end
   end

   // Ready lines are registered-state decodes; each flop drives its output directly.
   // Valid lines mirror the response states in flops of their own, so no output passes through a decode.
   logic awready_ff, wready_ff, arready_ff, bvalid_ff, rvalid_ff;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         arready_ff <= 1'b0;
         bvalid_ff  <= 1'b0;
         rvalid_ff  <= 1'b0;
      end else begin
         awready_ff <= !nxt_aw_got && nxt_wst == IPR_IDLE;
         wready_ff  <= !nxt_w_got && nxt_wst == IPR_IDLE;
         arready_ff <= nxt_rst == IPR_IDLE;
         bvalid_ff  <= nxt_wst == IPR_RESP;
         rvalid_ff  <= nxt_rst == IPR_RESP;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign irq_req       = req_ff;
   assign irq_src       = src_ff;
   assign irq_level     = lvl_ff;
   assign irq_sublevel  = sub_ff;
endmodule // ipr_top
`default_nettype wire

// [bench/ipr_top_props.sv]
// Checker of bus timing, register reads and arbitration results of the priority register block.
`timescale 1ns/1ns
`default_nettype none
module ipr_top_props
   import ipr_pkg::*;
(
   // Clock and reset.
   input wire logic        core_clk,
   input wire logic        rst,
   // Register bus.
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   // Interrupt side.
   input wire logic [2:0]  irq_pend,
   input wire logic        irq_req,
   input wire logic [1:0]  irq_src,
   input wire logic [2:0]  irq_level
);
   logic [3:0] ar_q;
   logic [2:0] pend_q;
   // The read address is kept so the answer can be judged against the place that was asked for.
   always_ff @(posedge core_clk) begin
      pend_q <= irq_pend;
      if (s_axi_arvalid && s_axi_arready) begin
         ar_q <= s_axi_araddr;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid; endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late or early");
   property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
   property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken while answering");
   property p_resv; s_axi_rvalid && ar_q[3:2] == 2'h0 |-> (s_axi_rdata & 32'hffe0_e0e0) == 32'h0; endproperty
   a_resv: assert property (p_resv) else $error("unused bits read nonzero");
   property p_unmap; s_axi_rvalid && ar_q[3:2] == 2'h3 |-> s_axi_rresp == IPR_RESP_SLVERR; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   property p_idle; irq_pend == 3'h0 |=> !irq_req; endproperty
   a_idle: assert property (p_idle) else $error("request with nothing pending");
   property p_lvl; irq_req |-> irq_level != IPR_PRIO_DISABLED; endproperty
   a_lvl: assert property (p_lvl) else $error("disabled source presented");
   property p_win; irq_req |-> pend_q[irq_src]; endproperty
   a_win: assert property (p_win) else $error("winner was not pending");
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == IPR_RESP_SLVERR);
   c_soft1: cover property (irq_req && irq_src == IPR_SRC_CS1);
   c_win: cover property (s_axi_rvalid && ar_q == IPR_OFF_WIN);
endmodule // ipr_top_props
bind ipr_top ipr_top_props ipr_top_props_inst (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
   .s_axi_rdata, .s_axi_rresp, .irq_pend, .irq_req, .irq_src, .irq_level);
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench of the interrupt priority register block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ipr_pkg::*;
   logic        core_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp, irq_src, irq_sublevel;
   logic [2:0]  irq_pend, irq_level;
   int          bad_count, compares, cycles;
   ipr_top ipr_top_inst (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq_pend,
      .irq_req, .irq_src, .irq_level, .irq_sublevel);
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic report_and_stop();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // A hang in a handshake wait is cut short here.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         $display("unexpected at %0t: run too long", $time);
         report_and_stop();
      end
   end
   task automatic check(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Address and data may be taken at different edges; each is released at its own.
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         #1;
      end while (s_axi_awvalid || s_axi_wvalid);
      do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp === er, "write response");
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata === ed && s_axi_rresp === er, "read data");
      @(posedge core_clk);
   endtask
   // Expected winner uses the layout {req, src, level, sub}; src is judged only when a request stands.
   task automatic irq(input logic [2:0] p, input logic [7:0] ew);
      irq_pend <= p;
      repeat (2) @(posedge core_clk);
      check({irq_req, irq_level, irq_sublevel} === {ew[7], ew[4:0]} && (!ew[7] || irq_src === ew[6:5]), "winner");
   endtask
   task automatic t_reset();
      rd(IPR_OFF_PRIO0, 32'h0, IPR_RESP_OKAY); // Reset value.
      irq(3'h7, 8'h00); // All disabled.
   endtask
   task automatic t_fields();
      wr(IPR_OFF_PRIO0, 32'hffff_ffff, 4'hf, IPR_RESP_OKAY);
      rd(IPR_OFF_PRIO0, 32'h001f_1f1f, IPR_RESP_OKAY); // Field bits only.
      wr(IPR_OFF_PRIO0, 32'h0, 4'h2, IPR_RESP_OKAY);
      rd(IPR_OFF_PRIO0, 32'h001f_001f, IPR_RESP_OKAY); // One lane cleared.
      wr(IPR_OFF_PRIO0, 32'h0014_0a11, 4'hf, IPR_RESP_OKAY);
      rd(IPR_OFF_PRIO0, 32'h0014_0a11, IPR_RESP_OKAY); // Distinct fields.
      irq(3'h1, 8'h91); // Tick level 4 sub 1.
      irq(3'h2, 8'haa); // Soft 0 level 2 sub 2.
   endtask
   task automatic t_levels();
      wr(IPR_OFF_PRIO0, 32'h0000_0003, 4'hf, IPR_RESP_OKAY);
      irq(3'h1, 8'h00); // Zero priority hides the source.
      for (int i = 1; i < 8; i++) begin
         for (int j = 0; j < 4; j++) begin
            wr(IPR_OFF_PRIO0, {27'h0, 3'(i), 2'(j)}, 4'hf, IPR_RESP_OKAY);
            irq(3'h1, {1'b1, IPR_SRC_CT, 3'(i), 2'(j)}); // Each code.
         end
      end
   endtask
   task automatic t_arb();
      wr(IPR_OFF_PRIO0, 32'h0016_1513, 4'hf, IPR_RESP_OKAY);
      irq(3'h7, 8'hd6); // Equal level, higher sub wins.
      rd(IPR_OFF_WIN, 32'h0000_00d6, IPR_RESP_OKAY); // Winner readback.
      irq(3'h3, 8'hb5); // Higher level beats higher sub.
      irq(3'h1, 8'h93); // Lone tick.
      rd(IPR_OFF_PEND, 32'h0000_0001, IPR_RESP_OKAY); // Pending mirror.
   endtask
   task automatic t_unmapped();
      wr(4'hc, 32'hffff_ffff, 4'hf, IPR_RESP_SLVERR);
      rd(4'hc, 32'h0, IPR_RESP_SLVERR); // Unmapped place.
      wr(IPR_OFF_WIN, 32'hffff_ffff, 4'hf, IPR_RESP_OKAY);
      rd(IPR_OFF_PRIO0, 32'h0016_1513, IPR_RESP_OKAY); // Register untouched.
   endtask
   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, irq_pend} = 47'h0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_fields();
      t_levels();
      t_arb();
      t_unmapped();
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
